// ===== core/csw_params.svh
// Offsets, field positions, reset values and timing counts of the clock switch
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSW_OFS_CTRL 8'h00
`define CSW_OFS_CFG 8'h04
`define CSW_OFS_INT 8'h08
`define CSW_OFS_SLOW 8'h0C

// ----------------------------------------
// Main clock control fields
// ----------------------------------------
`define CSW_CTRL_LOCKED 25
`define CSW_CTRL_LOOP_EN 24
`define CSW_CTRL_LOOP_OUT 23
`define CSW_CTRL_LOOP_BYP 22
`define CSW_CTRL_MON_EN 19
`define CSW_CTRL_FEXT_BYP 18
`define CSW_CTRL_FEXT_RDY 17
`define CSW_CTRL_FEXT_EN 16
`define CSW_CTRL_TRIM_HI 7
`define CSW_CTRL_TRIM_LO 3
`define CSW_CTRL_FINT_RDY 1
`define CSW_CTRL_FINT_EN 0
`define CSW_TRIM_RESET 5'h10

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CSW_CFG_SYS_LO 0
`define CSW_CFG_USED_LO 2
`define CSW_CFG_OUT_LO 4
`define CSW_CFG_LOOP_SRC 7
`define CSW_CFG_LPS_LO 8
`define CSW_CFG_LPT_LO 11

// ----------------------------------------
// Interrupt register fields
// ----------------------------------------
`define CSW_INT_SINT_IE 0
`define CSW_INT_SEXT_IE 1
`define CSW_INT_SINT_IF 8
`define CSW_INT_SEXT_IF 9
`define CSW_INT_FAIL_IF 10
`define CSW_INT_SINT_CLR 16
`define CSW_INT_SEXT_CLR 17
`define CSW_INT_FAIL_CLR 18

// ----------------------------------------
// Slow clock control fields
// ----------------------------------------
`define CSW_SLOW_SINT_EN 0
`define CSW_SLOW_SINT_RDY 1
`define CSW_SLOW_SEXT_EN 2
`define CSW_SLOW_SEXT_RDY 3
`define CSW_SLOW_SEXT_BYP 4
`define CSW_SLOW_RTC_LO 5
`define CSW_SLOW_WDG 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSW_CLK_NS 25
`define CSW_FAIL_NS 400
`define CSW_FAIL_CYC (`CSW_FAIL_NS / `CSW_CLK_NS)
`define CSW_BYPASS_MAX_HZ 1000000
`define CSW_RTC_HALF_DIV 64

`endif

// ===== core/csw_pkg.sv
// Types shared by the clock switch
package csw_pkg;

  // Oscillator bundle, one bit per source
  typedef struct packed {
    logic loop_clk;
    logic fast_ext;
    logic fast_int;
    logic slow_ext;
    logic slow_int;
  } csw_osc_t;

  // System clock source codes
  typedef enum logic [1:0] {
    CSW_SYS_FINT = 2'h0,
    CSW_SYS_FEXT = 2'h1,
    CSW_SYS_LOOP = 2'h2,
    CSW_SYS_SINT = 2'h3
  } csw_sys_src_t;

  // Glitch-free switch states
  typedef enum logic [2:0] {
    CSW_RUN = 3'b001,
    CSW_PARK = 3'b010,
    CSW_JOIN = 3'b100
  } csw_sw_state_t;

endpackage

// ===== core/csw_clock_switch.sv
// Clock source control, glitch-free switching and failure monitor
`timescale 1ns/100ps
`include "csw_params.svh"

module csw_clock_switch
  import csw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire csw_osc_t osc_clk_i,
  input wire csw_osc_t osc_stable_i,
  input wire logic pclk_i,
  input wire logic comp_out_i,
  input wire logic watchdog_start_i,
  output csw_osc_t osc_en_o,
  output logic slow_ext_bypass_o,
  output logic fast_ext_bypass_o,
  output logic loop_bypass_o,
  output logic loop_output_enable_o,
  output logic loop_source_o,
  output logic [4:0] fast_int_trim_o,
  output logic sys_clk_o,
  output logic [1:0] sys_src_o,
  output logic rtc_clk_o,
  output logic lps_clk_o,
  output logic lpt_clk_o,
  output logic clk_out_o,
  output logic watchdog_clk_o,
  output logic slow_ext_clk_o,
  output logic slow_int_clk_o,
  output logic ready_irq_o,
  output logic nmi_o,
  output logic timer_break_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Pick one level out of a source vector
  function automatic logic pick(input logic [5:0] src, input logic [2:0] sel);
    return (sel < 3'h6) ? src[sel] : 1'b0;
  endfunction

  // ----------------------------------------
  // Software state
  // ----------------------------------------
  logic fint_en, fext_en, loop_en, sint_en, sext_en;
  logic mon_en, fext_byp, loop_byp, loop_out, sext_byp;
  logic [4:0] trim;
  logic [1:0] sys_sel;
  logic [2:0] out_sel, lps_sel, lpt_sel;
  logic loop_src;
  logic [1:0] rtc_sel;
  logic sint_ie, sext_ie, sint_if, sext_if, fail_if;
  logic wdg_sw;
  logic [1:0] cur_src, tgt_src;
  csw_sw_state_t sw_state;

  // ----------------------------------------
  // Ready flags and usage
  // ----------------------------------------
  logic fint_rdy, fext_rdy, loop_rdy, sint_rdy, sext_rdy;
  logic fint_used, fext_used, loop_used, sint_used, wdg_on;
  logic fail_evt;

  // Ready = oscillator enabled and reported stable
  assign fint_rdy = fint_en & osc_stable_i.fast_int;
  assign fext_rdy = fext_en & osc_stable_i.fast_ext;
  assign loop_rdy = loop_en & osc_stable_i.loop_clk;
  assign sint_rdy = sint_en & osc_stable_i.slow_int;
  assign sext_rdy = sext_en & osc_stable_i.slow_ext;
  assign wdg_on = wdg_sw | watchdog_start_i;

  // Sources feeding the system clock, directly or via the loop, plus the slow internal one while the watchdog runs
  // The switch target counts too, so a half-done switch never lands on a dead source
  assign loop_used = (cur_src == CSW_SYS_LOOP) || (tgt_src == CSW_SYS_LOOP);
  assign fint_used = (cur_src == CSW_SYS_FINT) || (tgt_src == CSW_SYS_FINT)
                     || (loop_used & ~loop_src);
  assign fext_used = (cur_src == CSW_SYS_FEXT) || (tgt_src == CSW_SYS_FEXT)
                     || (loop_used & loop_src);
  assign sint_used = (cur_src == CSW_SYS_SINT) || (tgt_src == CSW_SYS_SINT) || wdg_on;

  // Ready of any system source code
  function automatic logic src_ready(input logic [1:0] s, input logic [3:0] rdy);
    return rdy[s];
  endfunction

  logic [3:0] sys_rdy_vec, sys_clk_vec;
  assign sys_rdy_vec = {sint_rdy, loop_rdy, fext_rdy, fint_rdy};
  assign sys_clk_vec = {osc_clk_i.slow_int, osc_clk_i.loop_clk,
                        osc_clk_i.fast_ext, osc_clk_i.fast_int};

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic wr, rd_hit;
  logic [31:0] ctrl_rd, cfg_rd, int_rd, slow_rd, ctrl_wr, cfg_wr, int_wr, slow_wr;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Readback images; bits not listed read zero
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`CSW_CTRL_LOCKED] = loop_rdy;
    ctrl_rd[`CSW_CTRL_LOOP_EN] = loop_en;
    ctrl_rd[`CSW_CTRL_LOOP_OUT] = loop_out;
    ctrl_rd[`CSW_CTRL_LOOP_BYP] = loop_byp;
    ctrl_rd[`CSW_CTRL_MON_EN] = mon_en;
    ctrl_rd[`CSW_CTRL_FEXT_BYP] = fext_byp;
    ctrl_rd[`CSW_CTRL_FEXT_RDY] = fext_rdy;
    ctrl_rd[`CSW_CTRL_FEXT_EN] = fext_en;
    ctrl_rd[`CSW_CTRL_TRIM_HI:`CSW_CTRL_TRIM_LO] = trim;
    ctrl_rd[`CSW_CTRL_FINT_RDY] = fint_rdy;
    ctrl_rd[`CSW_CTRL_FINT_EN] = fint_en;
    cfg_rd = 32'h0000_0000;
    cfg_rd[`CSW_CFG_SYS_LO +: 2] = sys_sel;
    cfg_rd[`CSW_CFG_USED_LO +: 2] = cur_src;
    cfg_rd[`CSW_CFG_OUT_LO +: 3] = out_sel;
    cfg_rd[`CSW_CFG_LOOP_SRC] = loop_src;
    cfg_rd[`CSW_CFG_LPS_LO +: 3] = lps_sel;
    cfg_rd[`CSW_CFG_LPT_LO +: 3] = lpt_sel;
    int_rd = 32'h0000_0000;
    int_rd[`CSW_INT_SINT_IE] = sint_ie;
    int_rd[`CSW_INT_SEXT_IE] = sext_ie;
    int_rd[`CSW_INT_SINT_IF] = sint_if;
    int_rd[`CSW_INT_SEXT_IF] = sext_if;
    int_rd[`CSW_INT_FAIL_IF] = fail_if;
    slow_rd = 32'h0000_0000;
    slow_rd[`CSW_SLOW_SINT_EN] = sint_en;
    slow_rd[`CSW_SLOW_SINT_RDY] = sint_rdy;
    slow_rd[`CSW_SLOW_SEXT_EN] = sext_en;
    slow_rd[`CSW_SLOW_SEXT_RDY] = sext_rdy;
    slow_rd[`CSW_SLOW_SEXT_BYP] = sext_byp;
    slow_rd[`CSW_SLOW_RTC_LO +: 2] = rtc_sel;
    slow_rd[`CSW_SLOW_WDG] = wdg_on;
  end

  assign ctrl_wr = merge(ctrl_rd, wb_dat_i, wb_sel_i);
  assign cfg_wr = merge(cfg_rd, wb_dat_i, wb_sel_i);
  assign int_wr = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign slow_wr = merge(slow_rd, wb_dat_i, wb_sel_i);

  // One wait state: ack and data one edge after the request
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_hit;
      if (rd_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          `CSW_OFS_CTRL: wb_dat_o <= ctrl_rd;
          `CSW_OFS_CFG: wb_dat_o <= cfg_rd;
          `CSW_OFS_INT: wb_dat_o <= int_rd;
          `CSW_OFS_SLOW: wb_dat_o <= slow_rd;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Failure monitor
  // ----------------------------------------
  logic fext_q, mon_active;
  logic [7:0] idle_cnt;
  assign mon_active = mon_en & fext_rdy;

  // Missing edges for the timeout count as a dead crystal
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fext_q <= 1'b0;
      idle_cnt <= 8'h00;
    end else begin
      fext_q <= osc_clk_i.fast_ext;
      if (!mon_active || (fext_q != osc_clk_i.fast_ext)) begin
        idle_cnt <= 8'h00;
      end else if (!fail_evt) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end
  assign fail_evt = mon_active && (idle_cnt == 8'(`CSW_FAIL_CYC));

  // Break pulse to both advanced timers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timer_break_o <= 1'b0;
    end else begin
      timer_break_o <= fail_evt;
    end
  end

  // ----------------------------------------
  // Fast oscillator and loop control
  // ----------------------------------------
  logic ctrl_we, cfg_we, int_we, slow_we;
  assign ctrl_we = wr && (wb_adr_i == `CSW_OFS_CTRL);
  assign cfg_we = wr && (wb_adr_i == `CSW_OFS_CFG);
  assign int_we = wr && (wb_adr_i == `CSW_OFS_INT);
  assign slow_we = wr && (wb_adr_i == `CSW_OFS_SLOW);

  // Hardware failure action wins over a software write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fint_en <= 1'b1;
      fext_en <= 1'b0;
      loop_en <= 1'b0;
      mon_en <= 1'b0;
      fext_byp <= 1'b0;
      loop_byp <= 1'b0;
      loop_out <= 1'b0;
      trim <= `CSW_TRIM_RESET;
    end else begin
      if (ctrl_we) begin
        fint_en <= ctrl_wr[`CSW_CTRL_FINT_EN] | fint_used;
        fext_en <= ctrl_wr[`CSW_CTRL_FEXT_EN] | fext_used;
        loop_en <= ctrl_wr[`CSW_CTRL_LOOP_EN] | loop_used;
        mon_en <= ctrl_wr[`CSW_CTRL_MON_EN];
        fext_byp <= ctrl_wr[`CSW_CTRL_FEXT_BYP];
        loop_byp <= ctrl_wr[`CSW_CTRL_LOOP_BYP];
        loop_out <= ctrl_wr[`CSW_CTRL_LOOP_OUT];
        trim <= ctrl_wr[`CSW_CTRL_TRIM_HI:`CSW_CTRL_TRIM_LO];
      end
      if (fail_evt) begin
        fext_en <= 1'b0;
        if (loop_src) begin
          loop_en <= 1'b0;
        end
      end
    end
  end

  // Configuration; loop source locked while loop runs
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sys_sel <= CSW_SYS_FINT;
      out_sel <= 3'h0;
      loop_src <= 1'b0;
      lps_sel <= 3'h0;
      lpt_sel <= 3'h0;
    end else begin
      if (cfg_we) begin
        sys_sel <= cfg_wr[`CSW_CFG_SYS_LO +: 2];
        out_sel <= cfg_wr[`CSW_CFG_OUT_LO +: 3];
        lps_sel <= cfg_wr[`CSW_CFG_LPS_LO +: 3];
        lpt_sel <= cfg_wr[`CSW_CFG_LPT_LO +: 3];
        if (!loop_en) begin
          loop_src <= cfg_wr[`CSW_CFG_LOOP_SRC];
        end
      end
      if (fail_evt && fext_used) begin
        sys_sel <= CSW_SYS_FINT;
      end
    end
  end

  // ----------------------------------------
  // Slow oscillators and watchdog
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sint_en <= 1'b0;
      sext_en <= 1'b0;
      sext_byp <= 1'b0;
      rtc_sel <= 2'h0;
      wdg_sw <= 1'b0;
    end else begin
      if (slow_we) begin
        sint_en <= slow_wr[`CSW_SLOW_SINT_EN] | sint_used;
        sext_en <= slow_wr[`CSW_SLOW_SEXT_EN];
        if (!sext_en) begin
          sext_byp <= slow_wr[`CSW_SLOW_SEXT_BYP];
        end
        rtc_sel <= slow_wr[`CSW_SLOW_RTC_LO +: 2];
        wdg_sw <= wdg_sw | slow_wr[`CSW_SLOW_WDG];
      end
      if (wdg_on) begin
        sint_en <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Ready interrupts and failure flag
  // ----------------------------------------
  logic sint_rdy_q, sext_rdy_q;

  // Set wins over a clear written in the same cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sint_rdy_q <= 1'b0;
      sext_rdy_q <= 1'b0;
      sint_ie <= 1'b0;
      sext_ie <= 1'b0;
      sint_if <= 1'b0;
      sext_if <= 1'b0;
      fail_if <= 1'b0;
    end else begin
      sint_rdy_q <= sint_rdy;
      sext_rdy_q <= sext_rdy;
      if (int_we) begin
        sint_ie <= int_wr[`CSW_INT_SINT_IE];
        sext_ie <= int_wr[`CSW_INT_SEXT_IE];
        if (int_wr[`CSW_INT_SINT_CLR]) begin
          sint_if <= 1'b0;
        end
        if (int_wr[`CSW_INT_SEXT_CLR]) begin
          sext_if <= 1'b0;
        end
        if (int_wr[`CSW_INT_FAIL_CLR]) begin
          fail_if <= 1'b0;
        end
      end
      if (sint_rdy && !sint_rdy_q) begin
        sint_if <= 1'b1;
      end
      if (sext_rdy && !sext_rdy_q) begin
        sext_if <= 1'b1;
      end
      if (fail_evt) begin
        fail_if <= 1'b1;
      end
    end
  end

  assign ready_irq_o = (sint_if & sint_ie) | (sext_if & sext_ie);
  assign nmi_o = fail_if;

  // ----------------------------------------
  // System clock switch
  // ----------------------------------------
  // Output parks low until old then new source are low, so no runt pulse; a failure fallback waits on the new source only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sw_state <= CSW_RUN;
      cur_src <= CSW_SYS_FINT;
      tgt_src <= CSW_SYS_FINT;
      sys_clk_o <= 1'b0;
    end else begin
      unique case (sw_state)
        CSW_RUN: begin
          sys_clk_o <= sys_clk_vec[cur_src];
          if (fail_evt && fext_used) begin
            tgt_src <= CSW_SYS_FINT;
            sw_state <= CSW_JOIN;
            sys_clk_o <= 1'b0;
          end else if (sys_sel != cur_src && src_ready(sys_sel, sys_rdy_vec)) begin
            tgt_src <= sys_sel;
            sw_state <= CSW_PARK;
          end
        end
        CSW_PARK: begin
          sys_clk_o <= 1'b0;
          if (!sys_clk_vec[cur_src]) begin
            sw_state <= CSW_JOIN;
          end
        end
        CSW_JOIN: begin
          sys_clk_o <= 1'b0;
          if (!sys_clk_vec[tgt_src]) begin
            cur_src <= tgt_src;
            sw_state <= CSW_RUN;
          end
        end
        default: begin
          sw_state <= CSW_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Dividers for the real-time and output clocks
  // ----------------------------------------
  logic fext_edge, rtc_div, loop_q, loop_div;
  logic [5:0] rtc_cnt;
  assign fext_edge = osc_clk_i.fast_ext & ~fext_q;

  // Fast external / 128 and loop clock / 2
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rtc_cnt <= 6'h00;
      rtc_div <= 1'b0;
      loop_q <= 1'b0;
      loop_div <= 1'b0;
    end else begin
      loop_q <= osc_clk_i.loop_clk;
      if (osc_clk_i.loop_clk && !loop_q) begin
        loop_div <= ~loop_div;
      end
      if (fext_edge) begin
        if (rtc_cnt == 6'(`CSW_RTC_HALF_DIV - 1)) begin
          rtc_cnt <= 6'h00;
          rtc_div <= ~rtc_div;
        end else begin
          rtc_cnt <= rtc_cnt + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Auxiliary glitch-free muxes
  // ----------------------------------------
  logic fint_g, fext_g, sint_g, sext_g;
  assign fint_g = osc_clk_i.fast_int & fint_rdy;
  assign fext_g = osc_clk_i.fast_ext & fext_rdy;
  assign sint_g = osc_clk_i.slow_int & sint_rdy;
  assign sext_g = osc_clk_i.slow_ext & sext_rdy;

  logic [5:0] aux_src [4];
  logic [2:0] aux_sel [4];
  logic [3:0] aux_out;

  // 0 real-time, 1 serial, 2 timer, 3 clock output
  always_comb begin
    aux_src[0] = {2'b00, rtc_div & fext_rdy, sint_g, sext_g, 1'b0};
    aux_sel[0] = {1'b0, rtc_sel};
    aux_src[1] = {pclk_i, sys_clk_o, sext_g, sint_g, fext_g, fint_g};
    aux_sel[1] = lps_sel;
    aux_src[2] = {comp_out_i, pclk_i, sext_g, sint_g, fext_g, fint_g};
    aux_sel[2] = lpt_sel;
    aux_src[3] = {loop_div, sext_g, sint_g, fext_g, fint_g, sys_clk_o};
    aux_sel[3] = out_sel;
  end

  // Each mux takes a new source only while both levels are low
  for (genvar m = 0; m < 4; m++) begin : g_aux
    logic [2:0] act;
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        act <= 3'h0;
        aux_out[m] <= 1'b0;
      end else if (act != aux_sel[m]) begin
        aux_out[m] <= 1'b0;
        if (!pick(aux_src[m], act) && !pick(aux_src[m], aux_sel[m])) begin
          act <= aux_sel[m];
        end
      end else begin
        aux_out[m] <= pick(aux_src[m], act);
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rtc_clk_o = aux_out[0];
  assign lps_clk_o = aux_out[1];
  assign lpt_clk_o = aux_out[2];
  assign clk_out_o = aux_out[3];
  assign osc_en_o = '{loop_clk: loop_en, fast_ext: fext_en, fast_int: fint_en,
                      slow_ext: sext_en, slow_int: sint_en};
  assign slow_ext_bypass_o = sext_byp;
  assign fast_ext_bypass_o = fext_byp;
  assign loop_bypass_o = loop_byp;
  assign loop_output_enable_o = loop_out;
  assign loop_source_o = loop_src;
  assign fast_int_trim_o = trim;
  assign sys_src_o = cur_src;
  assign slow_ext_clk_o = sext_g;
  assign slow_int_clk_o = sint_g;
  assign watchdog_clk_o = sint_g & wdg_on;

endmodule

// ===== verification/csw_clock_switch_asserts.sv
// Assertion checker for the clock switch, bound to its ports
`timescale 1ns/100ps
module csw_clock_switch_chk
  import csw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire csw_osc_t osc_clk_i,
  input wire csw_osc_t osc_stable_i,
  input wire logic watchdog_start_i,
  input wire csw_osc_t osc_en_o,
  input wire logic [1:0] sys_src_o,
  input wire logic slow_ext_clk_o,
  input wire logic slow_int_clk_o,
  input wire logic nmi_o,
  input wire logic timer_break_o
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic fail_clr;
  logic tgt_rdy;
  // Clear strobe on the taking edge; a held request must not count twice
  assign fail_clr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h08
    && wb_sel_i[2] && wb_dat_i[18];
  // Readiness of the source reported in use
  always_comb begin
    case (sys_src_o)
      2'h0: tgt_rdy = osc_en_o.fast_int && osc_stable_i.fast_int;
      2'h1: tgt_rdy = osc_en_o.fast_ext && osc_stable_i.fast_ext;
      2'h2: tgt_rdy = osc_en_o.loop_clk && osc_stable_i.loop_clk;
      default: tgt_rdy = osc_en_o.slow_int && osc_stable_i.slow_int;
    endcase
  end
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  property p_rst_src;
    $fell(reset_i) |-> sys_src_o == 2'h0 && osc_en_o.fast_int;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source wrong");
  property p_src_rdy;
    !$stable(sys_src_o) |-> tgt_rdy;
  endproperty
  a_src_rdy: assert property (p_src_rdy) else $error("switched to unready source");
  property p_nmi_hold;
    nmi_o && !fail_clr |=> nmi_o;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped uncleared");
  property p_brk;
    timer_break_o |-> nmi_o && !osc_en_o.fast_ext;
  endproperty
  a_brk: assert property (p_brk) else $error("failure effects missing");
  property p_brk_pulse;
    timer_break_o |=> !timer_break_o;
  endproperty
  a_brk_pulse: assert property (p_brk_pulse) else $error("break longer than a cycle");
  property p_fail_src;
    timer_break_o && sys_src_o == 2'h1 |-> ##[1:20] sys_src_o == 2'h0;
  endproperty
  a_fail_src: assert property (p_fail_src) else $error("no fallback after failure");
  property p_wdg;
    watchdog_start_i ##1 watchdog_start_i |-> osc_en_o.slow_int;
  endproperty
  a_wdg: assert property (p_wdg) else $error("slow internal not forced");
  property p_sext_gate;
    slow_ext_clk_o |-> osc_en_o.slow_ext && osc_stable_i.slow_ext && osc_clk_i.slow_ext;
  endproperty
  a_sext_gate: assert property (p_sext_gate) else $error("slow ext clock leaked");
  property p_sint_gate;
    slow_int_clk_o |-> osc_en_o.slow_int && osc_stable_i.slow_int && osc_clk_i.slow_int;
  endproperty
  a_sint_gate: assert property (p_sint_gate) else $error("slow int clock leaked");
  // Main scenarios reached
  c_fail: cover property (timer_break_o);
  c_sw: cover property (!$stable(sys_src_o) && sys_src_o == 2'h1);
  c_clr: cover property ($fell(nmi_o));
endmodule

bind csw_clock_switch csw_clock_switch_chk u_chk (.mclk_i, .reset_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .osc_clk_i, .osc_stable_i,
  .watchdog_start_i, .osc_en_o, .sys_src_o, .slow_ext_clk_o, .slow_int_clk_o, .nmi_o,
  .timer_break_o);

// ===== verification/tb_csw_clock_switch.sv
// Self-checking bench for the clock switch
`timescale 1ns/100ps
module tb_csw_clock_switch;
  import csw_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic wdg = 1'b0;
  logic run_fext = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [3:0] cnt = 4'h0;
  logic [4:0] trim;
  logic [1:0] src;
  logic ack, nmi, brk, irq, sbyp, lpt, rtc, cmp_q, sint_q;
  csw_osc_t oclk = 5'h00;
  csw_osc_t ostab = 5'h1F;
  csw_osc_t en_o;
  int n_fail = 0;
  int total_checks = 0;
  int k;

  // ----------------------------------------
  // Clock, oscillators, design
  // ----------------------------------------
  always #12.5 mclk_i = ~mclk_i;
  // Oscillator levels; freezing the fast external one fakes a failure
  // All sources but a frozen fast external one keep toggling so mux changes can complete
  always @(posedge mclk_i) begin
    cnt <= cnt + 4'h1;
    oclk <= {cnt[0], cnt[1] & run_fext, cnt[0], cnt[3], cnt[2]};
    cmp_q <= cnt[2];
    sint_q <= oclk.slow_int;
  end
  csw_clock_switch dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .osc_clk_i(oclk), .osc_stable_i(ostab), .pclk_i(cnt[1]),
    .comp_out_i(cnt[2]), .watchdog_start_i(wdg), .osc_en_o(en_o),
    .slow_ext_bypass_o(sbyp), .fast_ext_bypass_o(), .loop_bypass_o(),
    .loop_output_enable_o(), .loop_source_o(), .fast_int_trim_o(trim), .sys_clk_o(),
    .sys_src_o(src), .rtc_clk_o(rtc), .lps_clk_o(), .lpt_clk_o(lpt), .clk_out_o(),
    .watchdog_clk_o(), .slow_ext_clk_o(), .slow_int_clk_o(), .ready_irq_o(irq),
    .nmi_o(nmi), .timer_break_o(brk));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; holds the request until ack is sampled
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = dat_o;
    chk("ack", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_fail++;
    $display("BAD watchdog exp done seen hang");
    final_report();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    wbx(1'b0, 8'h00, 32'h0000_0000);
    chk("main", rdat, 32'h0000_0083);
    wbx(1'b0, 8'h04, 32'h0000_0000);
    chk("in_use", {28'h0, rdat[3:0]}, 32'h0);
    wbx(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", rdat, 32'h0);
    wbx(1'b1, 8'h00, 32'h0000_0029);
    chk("trim", {27'h0, trim}, 32'h5);
    // Bypass only moves while the slow external enable is low
    wbx(1'b1, 8'h08, 32'h0000_0002);
    wbx(1'b1, 8'h0C, 32'h0000_0010);
    chk("byp_set", {31'h0, sbyp}, 32'h1);
    wbx(1'b1, 8'h0C, 32'h0000_0004);
    wbx(1'b1, 8'h0C, 32'h0000_0014);
    chk("byp_held", {31'h0, sbyp}, 32'h0);
    chk("sext_en", {31'h0, en_o.slow_ext}, 32'h1);
    tick(3);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wbx(1'b0, 8'h0C, 32'h0000_0000);
    chk("sext_rdy", {31'h0, rdat[3]}, 32'h1);
    wbx(1'b1, 8'h08, 32'h0002_0002);
    tick(2);
    chk("irq_off", {31'h0, irq}, 32'h0);
    wbx(1'b1, 8'h0C, 32'h0000_0005);
    chk("sint_on", {31'h0, en_o.slow_int}, 32'h1);
    wbx(1'b1, 8'h0C, 32'h0000_0004);
    chk("sint_off", {31'h0, en_o.slow_int}, 32'h0);
    wdg <= 1'b1;
    wbx(1'b1, 8'h0C, 32'h0000_0004);
    tick(2);
    chk("sint_forced", {31'h0, en_o.slow_int}, 32'h1);
    // Request an unready source first; the switch must wait
    wbx(1'b1, 8'h04, 32'h0000_0001);
    tick(10);
    chk("src_wait", {30'h0, src}, 32'h0);
    wbx(1'b1, 8'h00, 32'h0001_0029);
    for (k = 0; k < 40 && src !== 2'h1; k++) tick(1);
    chk("src_fext", {30'h0, src}, 32'h1);
    wbx(1'b0, 8'h04, 32'h0000_0000);
    chk("in_use_fext", {30'h0, rdat[3:2]}, 32'h1);
    wbx(1'b1, 8'h00, 32'h0000_0029);
    chk("fext_kept", {31'h0, en_o.fast_ext}, 32'h1);
    // Monitor on, then stop the fast external clock
    wbx(1'b1, 8'h00, 32'h0009_0029);
    tick(4);
    run_fext <= 1'b0;
    for (k = 0; k < 40 && brk !== 1'b1; k++) tick(1);
    chk("break", {31'h0, brk}, 32'h1);
    chk("fext_off", {31'h0, en_o.fast_ext}, 32'h0);
    for (k = 0; k < 20 && src !== 2'h0; k++) tick(1);
    chk("fallback", {30'h0, src}, 32'h0);
    tick(5);
    chk("nmi_held", {31'h0, nmi}, 32'h1);
    wbx(1'b1, 8'h08, 32'h0004_0002);
    tick(1);
    chk("nmi_clr", {31'h0, nmi}, 32'h0);
    // Timer onto the comparator while the current clock still runs
    wbx(1'b1, 8'h04, 32'h0000_2C50);
    wbx(1'b0, 8'h04, 32'h0000_0000);
    chk("cfg", rdat, 32'h0000_2C50);
    wbx(1'b1, 8'h0C, 32'h0000_0045);
    tick(16);
    // Mux outputs lag their source by one edge
    repeat (8) begin
      tick(1);
      chk("lpt_comp", {31'h0, lpt}, {31'h0, cmp_q});
      chk("rtc_sint", {31'h0, rtc}, {31'h0, sint_q});
    end
    final_report();
  end
endmodule
